// ### common/csc_pkg.sv
// Constants and types shared by the output channel control logic
package csc_pkg;

  // Output population: A0 A1 A2 B0 B1 C0 C1 D E0 E1 clocks, A0..D companions
  localparam int CSC_NUM_CLK = 10;
  localparam int CSC_NUM_REF = 8;
  localparam int CSC_NUM_CH = 5;
  localparam int CSC_CH_W = 3;

  // Field widths
  localparam int CSC_AMP_W = 2;
  localparam int CSC_CPH_W = 8;
  localparam int CSC_RPH_W = 3;

  // Channel indices
  localparam logic [CSC_CH_W-1:0] CSC_CH_A = 3'h0;
  localparam logic [CSC_CH_W-1:0] CSC_CH_B = 3'h1;
  localparam logic [CSC_CH_W-1:0] CSC_CH_C = 3'h2;
  localparam logic [CSC_CH_W-1:0] CSC_CH_D = 3'h3;
  localparam logic [CSC_CH_W-1:0] CSC_CH_E = 3'h4;

  // Channel of each output, entry 0 in the low bits
  localparam logic [CSC_NUM_CLK*CSC_CH_W-1:0] CSC_CLK_CH_MAP = {
    CSC_CH_E, CSC_CH_E, CSC_CH_D, CSC_CH_C, CSC_CH_C,
    CSC_CH_B, CSC_CH_B, CSC_CH_A, CSC_CH_A, CSC_CH_A};
  localparam logic [CSC_NUM_REF*CSC_CH_W-1:0] CSC_REF_CH_MAP = {
    CSC_CH_D, CSC_CH_C, CSC_CH_C, CSC_CH_B,
    CSC_CH_B, CSC_CH_A, CSC_CH_A, CSC_CH_A};

  // Companion function select and divider source encodings
  localparam logic CSC_FSEL_CLOCK = 1'b0;
  localparam logic CSC_FSEL_SREF = 1'b1;
  localparam logic CSC_DIV_CHANNEL = 1'b0;
  localparam logic CSC_DIV_SREF = 1'b1;

  // Amplitude code required for SYSREF function (500 mV)
  localparam logic [CSC_AMP_W-1:0] CSC_AMP_SREF = 2'h1;

  // Reset values
  localparam logic [CSC_AMP_W-1:0] CSC_AMP_RST = 2'h0;
  localparam logic [CSC_CPH_W-1:0] CSC_CPH_ZERO = 8'h00;
  localparam logic [CSC_RPH_W-1:0] CSC_RPH_ZERO = 3'h0;

  // Resolved state of one output driver
  typedef enum logic [1:0] {
    CSC_OFF,
    CSC_LOW,
    CSC_RUN,
    CSC_BIAS
  } csc_ostate_t;

endpackage

// ### rtl/csc_clk_state.sv
// Output state resolution for an output in clock function
`timescale 1ns/10ps
module csc_clk_state (
  input wire logic pwr_off, // Effective power-off
  input wire logic enable, // Output enable
  input wire logic [csc_pkg::CSC_AMP_W-1:0] amp_sel, // Programmed swing
  output csc_pkg::csc_ostate_t state, // Resolved driver state
  output logic [csc_pkg::CSC_AMP_W-1:0] amp // Swing to driver
);
  import csc_pkg::*;

  always_comb begin
    if (pwr_off) begin
      state = CSC_OFF; // R10
    end else if (!enable) begin
      state = CSC_LOW; // R10
    end else begin
      state = CSC_RUN; // R10
    end
    // Code order is swing order, so the driver takes the code as is
    amp = amp_sel; // R11
  end

endmodule

// ### rtl/csc_sref_state.sv
// Output state resolution for a companion output in SYSREF function
`timescale 1ns/10ps
module csc_sref_state (
  input wire logic ch_pwr_off, // Channel power-off
  input wire logic enable, // Output enable
  input wire logic line_bias, // Line-bias select
  input wire logic event_active, // SYSREF event in progress
  output csc_pkg::csc_ostate_t state, // Resolved driver state
  output logic [csc_pkg::CSC_AMP_W-1:0] amp // Swing to driver
);
  import csc_pkg::*;

  always_comb begin
    if (ch_pwr_off) begin
      state = CSC_OFF; // R08
    end else if (line_bias) begin
      state = CSC_BIAS; // R12 R13
    end else if (!event_active) begin
      state = CSC_OFF; // R13
    end else if (!enable) begin
      state = CSC_LOW; // R12
    end else begin
      state = CSC_RUN; // R12
    end
    // Driver only meets the SYSREF level at the 500 mV code
    amp = CSC_AMP_SREF; // R12
  end

endmodule

// ### rtl/csc_out_ctrl.sv
// Output channel control: function select, divider, phase and driver state
// Overview of operation
// (R01) Channels A-D carry one to three clocks and companions; E two clocks.
// (R02) Channel E has no SYSREF; its two outputs always carry the clock.
// (R03) Each companion has a select bit: 0 copies clock, 1 is SYSREF.
// (R04) SYSREF companions are switched by the event sequence, not own bits.
// (R05) Clock-function companions use their own power, enable and amplitude.
// (R06) Clock function uses channel divider; SYSREF uses shared SYSREF divider.
// (R07) Clock function takes channel phase; SYSREF uses its own SYSREF phase.
// (R08) Clock-function outputs power down per output; SYSREF ones per channel.
// (R09) Every clock and companion output has its own enable bit.
// (R10) Power-off 1 turns off; else enable 0 static low, 1 toggles.
// (R11) Two-bit amplitude codes 00..11 give 250 to 1000 mV swing.
// (R12) SYSREF: bias 1 holds bias; else enable low/active; amplitude 01.
// (R13) Event powers SYSREF outputs on, off after; bias ones hold crosspoint.
`timescale 1ns/10ps
module csc_out_ctrl
  import csc_pkg::*;
(
  input wire logic CLK, // 100 MHz clock
  input wire logic SRST, // Synchronous reset, active high
  input wire logic [csc_pkg::CSC_NUM_CH-1:0] CH_POWER_OFF, // Per channel
  input wire logic [csc_pkg::CSC_NUM_CH*csc_pkg::CSC_CPH_W-1:0] CH_PHASE, // Clock phase
  input wire logic [csc_pkg::CSC_NUM_CLK-1:0] CLK_OUTPUT_POWER_OFF, // Per clock
  input wire logic [csc_pkg::CSC_NUM_CLK-1:0] CLK_OUTPUT_ENABLE, // Per clock
  input wire logic [csc_pkg::CSC_NUM_CLK*csc_pkg::CSC_AMP_W-1:0] CLK_OUTPUT_AMP, // Swing
  input wire logic [csc_pkg::CSC_NUM_REF-1:0] COMPANION_FUNCTION_SELECT, // 1 SYSREF
  input wire logic [csc_pkg::CSC_NUM_REF-1:0] COMPANION_OUTPUT_POWER_OFF, // Per output
  input wire logic [csc_pkg::CSC_NUM_REF-1:0] COMPANION_OUTPUT_ENABLE, // Per output
  input wire logic [csc_pkg::CSC_NUM_REF*csc_pkg::CSC_AMP_W-1:0] COMPANION_OUTPUT_AMP, // Swing
  input wire logic [csc_pkg::CSC_NUM_REF-1:0] LINE_BIAS_SELECT, // Bias hold
  input wire logic [csc_pkg::CSC_NUM_REF*csc_pkg::CSC_RPH_W-1:0] SREF_COARSE, // Coarse
  input wire logic [csc_pkg::CSC_NUM_REF*csc_pkg::CSC_RPH_W-1:0] SREF_FINE, // Fine
  input wire logic SREF_EVENT, // SYSREF event in progress
  output csc_pkg::csc_ostate_t [csc_pkg::CSC_NUM_CLK-1:0] CLK_OUTPUT_STATE, // State
  output logic [csc_pkg::CSC_NUM_CLK*csc_pkg::CSC_AMP_W-1:0] CLK_OUTPUT_SWING, // Swing
  output logic [csc_pkg::CSC_NUM_CLK*csc_pkg::CSC_CPH_W-1:0] CLK_OUTPUT_PHASE, // Phase
  output csc_pkg::csc_ostate_t [csc_pkg::CSC_NUM_REF-1:0] COMPANION_OUTPUT_STATE, // State
  output logic [csc_pkg::CSC_NUM_REF*csc_pkg::CSC_AMP_W-1:0] COMPANION_OUTPUT_SWING, // Swing
  output logic [csc_pkg::CSC_NUM_REF-1:0] COMPANION_DIV_SEL, // 1 SYSREF divider
  output logic [csc_pkg::CSC_NUM_REF*csc_pkg::CSC_CPH_W-1:0] COMPANION_CLK_PHASE, // Phase
  output logic [csc_pkg::CSC_NUM_REF*csc_pkg::CSC_RPH_W-1:0] COMPANION_SREF_COARSE, // Coarse
  output logic [csc_pkg::CSC_NUM_REF*csc_pkg::CSC_RPH_W-1:0] COMPANION_SREF_FINE, // Fine
  output logic [csc_pkg::CSC_NUM_REF-1:0] COMPANION_AMP_MISMATCH // SYSREF amp not 01
);
  import csc_pkg::*;

  csc_ostate_t [CSC_NUM_CLK-1:0] clk_st_d, clk_st_q;
  logic [CSC_NUM_CLK*CSC_AMP_W-1:0] clk_amp_d, clk_amp_q;
  logic [CSC_NUM_CLK*CSC_CPH_W-1:0] clk_ph_d, clk_ph_q;
  logic [CSC_NUM_CLK-1:0] clk_off_w;

  csc_ostate_t [CSC_NUM_REF-1:0] rc_st_w, rs_st_w, ref_st_d, ref_st_q;
  logic [CSC_NUM_REF*CSC_AMP_W-1:0] rc_amp_w, rs_amp_w;
  logic [CSC_NUM_REF*CSC_AMP_W-1:0] ref_amp_d, ref_amp_q;
  logic [CSC_NUM_REF*CSC_CPH_W-1:0] ref_chph_w, ref_cph_d, ref_cph_q;
  logic [CSC_NUM_REF*CSC_RPH_W-1:0] ref_crs_d, ref_crs_q;
  logic [CSC_NUM_REF*CSC_RPH_W-1:0] ref_fin_d, ref_fin_q;
  logic [CSC_NUM_REF-1:0] ref_div_d, ref_div_q;
  logic [CSC_NUM_REF-1:0] ref_mis_d, ref_mis_q;
  logic [CSC_NUM_REF-1:0] ref_choff_w;

  // Clock outputs: channel power-off also stops every clock in the channel
  for (genvar i = 0; i < CSC_NUM_CLK; i++) begin : g_clk // R01
    localparam int CH = int'(CSC_CLK_CH_MAP[i*CSC_CH_W +: CSC_CH_W]);
    assign clk_off_w[i] = CLK_OUTPUT_POWER_OFF[i] | CH_POWER_OFF[CH]; // R08
    assign clk_ph_d[i*CSC_CPH_W +: CSC_CPH_W] =
      CH_PHASE[CH*CSC_CPH_W +: CSC_CPH_W]; // R02
    csc_clk_state u_state (
      .pwr_off(clk_off_w[i]),
      .enable(CLK_OUTPUT_ENABLE[i]), // R09
      .amp_sel(CLK_OUTPUT_AMP[i*CSC_AMP_W +: CSC_AMP_W]),
      .state(clk_st_d[i]),
      .amp(clk_amp_d[i*CSC_AMP_W +: CSC_AMP_W])
    );
  end

  // Companion outputs: both resolutions built, function select picks one
  for (genvar r = 0; r < CSC_NUM_REF; r++) begin : g_ref // R01
    localparam int CH = int'(CSC_REF_CH_MAP[r*CSC_CH_W +: CSC_CH_W]);
    assign ref_choff_w[r] = CH_POWER_OFF[CH];
    assign ref_chph_w[r*CSC_CPH_W +: CSC_CPH_W] =
      CH_PHASE[CH*CSC_CPH_W +: CSC_CPH_W];
    csc_clk_state u_clk (
      .pwr_off(COMPANION_OUTPUT_POWER_OFF[r]), // R05
      .enable(COMPANION_OUTPUT_ENABLE[r]),
      .amp_sel(COMPANION_OUTPUT_AMP[r*CSC_AMP_W +: CSC_AMP_W]),
      .state(rc_st_w[r]),
      .amp(rc_amp_w[r*CSC_AMP_W +: CSC_AMP_W])
    );
    csc_sref_state u_sref (
      .ch_pwr_off(ref_choff_w[r]), // R08
      .enable(COMPANION_OUTPUT_ENABLE[r]), // R09
      .line_bias(LINE_BIAS_SELECT[r]),
      .event_active(SREF_EVENT), // R13
      .state(rs_st_w[r]),
      .amp(rs_amp_w[r*CSC_AMP_W +: CSC_AMP_W])
    );
  end

  always_comb begin
    for (int r = 0; r < CSC_NUM_REF; r++) begin
      if (COMPANION_FUNCTION_SELECT[r] == CSC_FSEL_SREF) begin // R03
        // Own power-off bit has no say here, the sequence owns the driver
        ref_st_d[r] = rs_st_w[r]; // R04
        ref_amp_d[r*CSC_AMP_W +: CSC_AMP_W] =
          rs_amp_w[r*CSC_AMP_W +: CSC_AMP_W];
        ref_div_d[r] = CSC_DIV_SREF; // R06
        ref_cph_d[r*CSC_CPH_W +: CSC_CPH_W] = CSC_CPH_ZERO;
        ref_crs_d[r*CSC_RPH_W +: CSC_RPH_W] =
          SREF_COARSE[r*CSC_RPH_W +: CSC_RPH_W]; // R07
        ref_fin_d[r*CSC_RPH_W +: CSC_RPH_W] =
          SREF_FINE[r*CSC_RPH_W +: CSC_RPH_W]; // R07
        ref_mis_d[r] = COMPANION_OUTPUT_AMP[r*CSC_AMP_W +: CSC_AMP_W]
          != CSC_AMP_SREF; // R12
      end else begin
        ref_st_d[r] = rc_st_w[r]; // R05
        ref_amp_d[r*CSC_AMP_W +: CSC_AMP_W] =
          rc_amp_w[r*CSC_AMP_W +: CSC_AMP_W]; // R11
        ref_div_d[r] = CSC_DIV_CHANNEL; // R06
        ref_cph_d[r*CSC_CPH_W +: CSC_CPH_W] =
          ref_chph_w[r*CSC_CPH_W +: CSC_CPH_W]; // R07
        // SYSREF delay settings are ignored in clock function
        ref_crs_d[r*CSC_RPH_W +: CSC_RPH_W] = CSC_RPH_ZERO; // R07
        ref_fin_d[r*CSC_RPH_W +: CSC_RPH_W] = CSC_RPH_ZERO;
        ref_mis_d[r] = 1'b0;
      end
    end
  end

  // Registered so that every driver control changes on one edge
  always_ff @(posedge CLK) begin
    if (SRST) begin
      clk_st_q <= '{default: CSC_OFF};
      clk_amp_q <= {CSC_NUM_CLK{CSC_AMP_RST}};
      clk_ph_q <= {CSC_NUM_CLK{CSC_CPH_ZERO}};
      ref_st_q <= '{default: CSC_OFF};
      ref_amp_q <= {CSC_NUM_REF{CSC_AMP_RST}};
      ref_div_q <= {CSC_NUM_REF{CSC_DIV_CHANNEL}};
      ref_cph_q <= {CSC_NUM_REF{CSC_CPH_ZERO}};
      ref_crs_q <= {CSC_NUM_REF{CSC_RPH_ZERO}};
      ref_fin_q <= {CSC_NUM_REF{CSC_RPH_ZERO}};
      ref_mis_q <= '0;
    end else begin
      clk_st_q <= clk_st_d;
      clk_amp_q <= clk_amp_d;
      clk_ph_q <= clk_ph_d;
      ref_st_q <= ref_st_d;
      ref_amp_q <= ref_amp_d;
      ref_div_q <= ref_div_d;
      ref_cph_q <= ref_cph_d;
      ref_crs_q <= ref_crs_d;
      ref_fin_q <= ref_fin_d;
      ref_mis_q <= ref_mis_d;
    end
  end

  assign CLK_OUTPUT_STATE = clk_st_q;
  assign CLK_OUTPUT_SWING = clk_amp_q;
  assign CLK_OUTPUT_PHASE = clk_ph_q;
  assign COMPANION_OUTPUT_STATE = ref_st_q;
  assign COMPANION_OUTPUT_SWING = ref_amp_q;
  assign COMPANION_DIV_SEL = ref_div_q;
  assign COMPANION_CLK_PHASE = ref_cph_q;
  assign COMPANION_SREF_COARSE = ref_crs_q;
  assign COMPANION_SREF_FINE = ref_fin_q;
  assign COMPANION_AMP_MISMATCH = ref_mis_q;

  // Checks on the registered outputs against last cycle's settings
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST);

  property p_clk_off;
    !SRST && (CLK_OUTPUT_POWER_OFF[1] || CH_POWER_OFF[0]) |=>
      CLK_OUTPUT_STATE[1] == CSC_OFF;
  endproperty
  a_clk_off: assert property (p_clk_off) // R10
    else $error("clock output not off under power-off");

  property p_clk_low;
    !SRST && !CLK_OUTPUT_POWER_OFF[9] && !CH_POWER_OFF[4] &&
      !CLK_OUTPUT_ENABLE[9]
      |=> CLK_OUTPUT_STATE[9] == CSC_LOW;
  endproperty
  a_clk_low: assert property (p_clk_low) // R09
    else $error("disabled clock output not static low");

  property p_clk_run;
    !SRST && !CLK_OUTPUT_POWER_OFF[3] && !CH_POWER_OFF[1] &&
      CLK_OUTPUT_ENABLE[3]
      |=> CLK_OUTPUT_STATE[3] == CSC_RUN &&
          CLK_OUTPUT_SWING[3*CSC_AMP_W +: CSC_AMP_W] ==
          $past(CLK_OUTPUT_AMP[3*CSC_AMP_W +: CSC_AMP_W]);
  endproperty
  a_clk_run: assert property (p_clk_run) // R11
    else $error("enabled clock output not toggling at programmed swing");

  property p_e_phase;
    !SRST |=> CLK_OUTPUT_PHASE[8*CSC_CPH_W +: CSC_CPH_W] ==
      $past(CH_PHASE[4*CSC_CPH_W +: CSC_CPH_W]) &&
      CLK_OUTPUT_PHASE[9*CSC_CPH_W +: CSC_CPH_W] ==
      $past(CH_PHASE[4*CSC_CPH_W +: CSC_CPH_W]);
  endproperty
  a_e_phase: assert property (p_e_phase) // R02
    else $error("fifth channel clocks not on channel phase");

  property p_div_sel;
    !SRST |=> COMPANION_DIV_SEL == $past(COMPANION_FUNCTION_SELECT);
  endproperty
  a_div_sel: assert property (p_div_sel) // R06
    else $error("companion divider source does not follow select");

  property p_ref_clk_phase;
    !SRST && !COMPANION_FUNCTION_SELECT[7] |=>
      COMPANION_CLK_PHASE[7*CSC_CPH_W +: CSC_CPH_W] ==
      $past(CH_PHASE[3*CSC_CPH_W +: CSC_CPH_W]) &&
      COMPANION_SREF_COARSE[7*CSC_RPH_W +: CSC_RPH_W] == CSC_RPH_ZERO;
  endproperty
  a_ref_clk_phase: assert property (p_ref_clk_phase) // R07
    else $error("clock-function companion not on channel phase");

  property p_ref_sref_phase;
    !SRST && COMPANION_FUNCTION_SELECT[2] |=>
      COMPANION_SREF_COARSE[2*CSC_RPH_W +: CSC_RPH_W] ==
      $past(SREF_COARSE[2*CSC_RPH_W +: CSC_RPH_W]) &&
      COMPANION_SREF_FINE[2*CSC_RPH_W +: CSC_RPH_W] ==
      $past(SREF_FINE[2*CSC_RPH_W +: CSC_RPH_W]);
  endproperty
  a_ref_sref_phase: assert property (p_ref_sref_phase) // R07
    else $error("SYSREF companion not on its own phase");

  property p_ref_clk_state;
    !SRST && !COMPANION_FUNCTION_SELECT[0] &&
      COMPANION_OUTPUT_POWER_OFF[0] |=>
      COMPANION_OUTPUT_STATE[0] == CSC_OFF;
  endproperty
  a_ref_clk_state: assert property (p_ref_clk_state) // R05
    else $error("clock-function companion ignores its power-off");

  property p_ref_chpd;
    !SRST && COMPANION_FUNCTION_SELECT[3] && CH_POWER_OFF[1] |=>
      COMPANION_OUTPUT_STATE[3] == CSC_OFF;
  endproperty
  a_ref_chpd: assert property (p_ref_chpd) // R08
    else $error("SYSREF companion not off under channel power-off");

  property p_ref_bias;
    !SRST && COMPANION_FUNCTION_SELECT[3] && !CH_POWER_OFF[1] &&
      LINE_BIAS_SELECT[3]
      |=> COMPANION_OUTPUT_STATE[3] == CSC_BIAS;
  endproperty
  a_ref_bias: assert property (p_ref_bias) // R12
    else $error("biased SYSREF companion not at bias level");

  property p_ref_idle;
    !SRST && COMPANION_FUNCTION_SELECT[4] && !CH_POWER_OFF[1] &&
      !LINE_BIAS_SELECT[4] && !SREF_EVENT
      |=> COMPANION_OUTPUT_STATE[4] == CSC_OFF;
  endproperty
  a_ref_idle: assert property (p_ref_idle) // R13
    else $error("SYSREF companion on outside an event");

  property p_ref_event;
    !SRST && COMPANION_FUNCTION_SELECT[5] && !CH_POWER_OFF[2] &&
      !LINE_BIAS_SELECT[5] && SREF_EVENT && COMPANION_OUTPUT_ENABLE[5]
      |=> COMPANION_OUTPUT_STATE[5] == CSC_RUN &&
          COMPANION_OUTPUT_SWING[5*CSC_AMP_W +: CSC_AMP_W] == CSC_AMP_SREF;
  endproperty
  a_ref_event: assert property (p_ref_event) // R04
    else $error("SYSREF companion not active during event");

  property p_ref_ev_low;
    !SRST && COMPANION_FUNCTION_SELECT[7] && !CH_POWER_OFF[3] &&
      !LINE_BIAS_SELECT[7] && SREF_EVENT && !COMPANION_OUTPUT_ENABLE[7]
      |=> COMPANION_OUTPUT_STATE[7] == CSC_LOW;
  endproperty
  a_ref_ev_low: assert property (p_ref_ev_low) // R12
    else $error("disabled SYSREF companion not static low in event");

  property p_ref_clk_low;
    !SRST && !COMPANION_FUNCTION_SELECT[6] &&
      !COMPANION_OUTPUT_POWER_OFF[6] && !COMPANION_OUTPUT_ENABLE[6]
      |=> COMPANION_OUTPUT_STATE[6] == CSC_LOW;
  endproperty
  a_ref_clk_low: assert property (p_ref_clk_low) // R10
    else $error("disabled clock-function companion not static low");

  property p_ref_clk_swing;
    !SRST && !COMPANION_FUNCTION_SELECT[1] |=>
      COMPANION_OUTPUT_SWING[1*CSC_AMP_W +: CSC_AMP_W] ==
      $past(COMPANION_OUTPUT_AMP[1*CSC_AMP_W +: CSC_AMP_W]);
  endproperty
  a_ref_clk_swing: assert property (p_ref_clk_swing) // R11
    else $error("clock-function companion swing not as programmed");

  property p_ref_sref_swing;
    !SRST && COMPANION_FUNCTION_SELECT[6] |=>
      COMPANION_OUTPUT_SWING[6*CSC_AMP_W +: CSC_AMP_W] == CSC_AMP_SREF;
  endproperty
  a_ref_sref_swing: assert property (p_ref_sref_swing) // R12
    else $error("SYSREF companion swing not at fixed code");

  property p_ref_mis;
    !SRST |=> COMPANION_AMP_MISMATCH[0] ==
      $past(COMPANION_FUNCTION_SELECT[0] &&
      COMPANION_OUTPUT_AMP[0 +: CSC_AMP_W] != CSC_AMP_SREF);
  endproperty
  a_ref_mis: assert property (p_ref_mis) // R12
    else $error("amplitude mismatch flag wrong");

  c_event_run: cover property (SREF_EVENT &&
    COMPANION_FUNCTION_SELECT[5] ##1 COMPANION_OUTPUT_STATE[5] == CSC_RUN);
  c_ref_bias: cover property (COMPANION_OUTPUT_STATE[3] == CSC_BIAS);
  c_clk_low: cover property (CLK_OUTPUT_STATE[9] == CSC_LOW);
  c_mismatch: cover property (COMPANION_AMP_MISMATCH[0]);

endmodule

// ### testbench/csc_conv_model.sv
// Converter-side model watching the companion lanes for stray SYSREF edges
`timescale 1ns/10ps
module csc_conv_model
  import csc_pkg::*;
(
  input wire logic clk, // Bench clock
  input wire logic srst, // Synchronous reset, active high
  input wire logic [csc_pkg::CSC_NUM_REF-1:0] fsel, // Function select
  input wire logic evt, // SYSREF event in progress
  input csc_pkg::csc_ostate_t [csc_pkg::CSC_NUM_REF-1:0] ref_state, // Lanes
  output logic ok // Low once a SYSREF lane toggled outside an event
);
  import csc_pkg::*;
  logic [CSC_NUM_REF-1:0] fsel_q;
  logic evt_q;
  logic ok_q;
  logic ok_d;
  // States lag inputs by one edge, so judge them against registered inputs
  always_comb begin
    ok_d = ok_q;
    for (int j = 0; j < CSC_NUM_REF; j++) begin
      if (fsel_q[j] && ref_state[j] == CSC_RUN && !evt_q) begin
        ok_d = 1'b0;
      end
    end
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      fsel_q <= '0;
      evt_q <= 1'b0;
      ok_q <= 1'b1;
    end else begin
      fsel_q <= fsel;
      evt_q <= evt;
      ok_q <= ok_d;
    end
  end
  assign ok = ok_q;
endmodule

// ### testbench/csc_out_ctrl_tb.sv
// Randomised self-checking bench for the output channel control block
`timescale 1ns/10ps
module csc_out_ctrl_tb;
  import csc_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [4:0] ch_pd = '0;
  logic [39:0] ch_ph = '0;
  logic [9:0] k_pd = '0;
  logic [9:0] k_en = '0;
  logic [19:0] k_amp = '0;
  logic [7:0] fsel = '0;
  logic [7:0] r_pd = '0;
  logic [7:0] r_en = '0;
  logic [7:0] bias = '0;
  logic [15:0] r_amp = '0;
  logic [23:0] crs = '0;
  logic [23:0] fin = '0;
  logic evt = 1'b0;
  csc_ostate_t [CSC_NUM_CLK-1:0] k_st;
  csc_ostate_t [CSC_NUM_REF-1:0] r_st;
  logic [19:0] k_sw;
  logic [79:0] k_ph;
  logic [15:0] r_sw;
  logic [7:0] r_div;
  logic [7:0] r_mis;
  logic [63:0] r_cph;
  logic [23:0] r_crs;
  logic [23:0] r_fin;
  logic conv_ok;
  int fails = 0;
  int checks = 0;
  int cycles = 0;

  csc_out_ctrl u_dut (.CLK(clk), .SRST(srst), .CH_POWER_OFF(ch_pd),
    .CH_PHASE(ch_ph), .CLK_OUTPUT_POWER_OFF(k_pd), .CLK_OUTPUT_ENABLE(k_en),
    .CLK_OUTPUT_AMP(k_amp), .COMPANION_FUNCTION_SELECT(fsel),
    .COMPANION_OUTPUT_POWER_OFF(r_pd), .COMPANION_OUTPUT_ENABLE(r_en),
    .COMPANION_OUTPUT_AMP(r_amp), .LINE_BIAS_SELECT(bias),
    .SREF_COARSE(crs), .SREF_FINE(fin), .SREF_EVENT(evt),
    .CLK_OUTPUT_STATE(k_st), .CLK_OUTPUT_SWING(k_sw),
    .CLK_OUTPUT_PHASE(k_ph), .COMPANION_OUTPUT_STATE(r_st),
    .COMPANION_OUTPUT_SWING(r_sw), .COMPANION_DIV_SEL(r_div),
    .COMPANION_CLK_PHASE(r_cph), .COMPANION_SREF_COARSE(r_crs),
    .COMPANION_SREF_FINE(r_fin), .COMPANION_AMP_MISMATCH(r_mis));

  csc_conv_model u_conv (.clk(clk), .srst(srst), .fsel(fsel), .evt(evt),
    .ref_state(r_st), .ok(conv_ok));

  function automatic logic [1:0] st_clk(logic pd, logic en);
    if (pd) return CSC_OFF;
    return en ? CSC_RUN : CSC_LOW;
  endfunction

  function automatic logic [1:0] st_ref(int j);
    if (!fsel[j]) return st_clk(r_pd[j], r_en[j]);
    if (ch_pd[CSC_REF_CH_MAP[j*3 +: 3]]) return CSC_OFF;
    if (bias[j]) return CSC_BIAS;
    if (!evt) return CSC_OFF;
    return r_en[j] ? CSC_RUN : CSC_LOW;
  endfunction

  task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("FAIL %s expected %0h seen %0h", name, exp, got);
    end
  endtask

  task automatic conclude();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic drive(int k);
    logic [63:0] r1;
    logic [63:0] r2;
    logic [63:0] r3;
    r1 = {$urandom(), $urandom()};
    r2 = {$urandom(), $urandom()};
    r3 = {$urandom(), $urandom()};
    ch_ph <= r2[39:0];
    k_pd <= r1[19:10] & r1[29:20];
    k_amp <= r3[19:0];
    r_pd <= r1[55:48] & r1[63:56];
    // Software keeps 01 on SYSREF lanes; every third vector breaks it
    r_amp <= (k % 3 == 0) ? r3[35:20] : 16'h5555;
    crs <= r3[59:36];
    fin <= r2[63:40];
    if (k < 4) begin
      ch_pd <= (k == 3) ? 5'h05 : 5'h00;
      k_en <= (k == 0) ? 10'h000 : 10'h3FF;
      fsel <= (k == 0) ? 8'h00 : 8'hFF;
      r_en <= (k == 3) ? 8'h55 : 8'hFF;
      bias <= (k == 2) ? 8'h0F : 8'h00;
      evt <= (k != 2);
    end else begin
      ch_pd <= r1[4:0] & r1[9:5];
      k_en <= r1[39:30];
      fsel <= r1[47:40];
      r_en <= r2[47:40];
      bias <= r3[63:60] == 4'hF ? r1[47:40] : 8'h00;
      evt <= r3[62];
    end
  endtask

  task automatic check_all();
    logic [2:0] ch;
    for (int i = 0; i < CSC_NUM_CLK; i++) begin
      ch = CSC_CLK_CH_MAP[i*3 +: 3];
      chk("clk state", st_clk(k_pd[i] | ch_pd[ch], k_en[i]), k_st[i]);
      chk("clk phase", ch_ph[ch*8 +: 8], k_ph[i*8 +: 8]);
      if (k_st[i] != CSC_OFF) chk("clk swing", k_amp[i*2 +: 2], k_sw[i*2 +: 2]);
    end
    for (int j = 0; j < CSC_NUM_REF; j++) begin
      ch = CSC_REF_CH_MAP[j*3 +: 3];
      chk("ref state", st_ref(j), r_st[j]);
      chk("ref div", fsel[j] ? CSC_DIV_SREF : CSC_DIV_CHANNEL, r_div[j]);
      chk("ref cph", fsel[j] ? 8'h00 : ch_ph[ch*8 +: 8], r_cph[j*8 +: 8]);
      chk("ref crs", fsel[j] ? crs[j*3 +: 3] : 3'h0, r_crs[j*3 +: 3]);
      chk("ref fin", fsel[j] ? fin[j*3 +: 3] : 3'h0, r_fin[j*3 +: 3]);
      chk("ref mis", fsel[j] && r_amp[j*2 +: 2] != 2'h1, r_mis[j]);
      if (fsel[j]) chk("ref swing", CSC_AMP_SREF, r_sw[j*2 +: 2]);
      else if (r_st[j] != CSC_OFF) chk("ref swing", r_amp[j*2 +: 2], r_sw[j*2 +: 2]);
    end
  endtask

  initial begin
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      conclude();
    end
  end

  initial begin
    void'($urandom(75));
    repeat (16) @(posedge clk);
    #1;
    chk("reset clk state", 32'h0, k_st);
    chk("reset ref state", 32'h0, r_st);
    for (int k = 0; k < 600; k++) begin
      @(posedge clk);
      srst <= 1'b0;
      drive(k);
      @(posedge clk);
      #1;
      check_all();
    end
    chk("conv ok", 32'h1, conv_ok);
    conclude();
  end
endmodule
